// ---- prw_cpu_model.sv ----
// Processor model that kicks the watchdog while its program runs
`timescale 1ns/100ps
`default_nettype none

module prw_cpu_model (
  // Clock and processor reset
  input  wire logic       i_clk,
  input  wire logic       i_cpu_reset_n,
  // Bench control
  input  wire logic       i_healthy,
  input  wire logic [7:0] i_period,
  // Watchdog pulse
  output logic            o_kick
);
  logic [7:0] cnt_q;

  // ==========================================================
  // Kick generator; a hung program simply stops kicking
  always @(negedge i_clk) begin
    if (!i_cpu_reset_n || !i_healthy) begin
      cnt_q  <= 8'h00;
      o_kick <= 1'b0;
    end else if (o_kick) begin
      o_kick <= 1'b0;
    end else if (cnt_q >= i_period) begin
      o_kick <= 1'b1;
      cnt_q  <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // prw_cpu_model

`default_nettype wire

// ---- prw_defs.svh ----
// Timing constants for the processor reset watchdog
`ifndef PRW_DEFS_SVH
`define PRW_DEFS_SVH

// ==========================================================
// Clock and timing
`define PRW_CLK_PERIOD_NS    25
`define PRW_WINDOW_NS        1000000000
`define PRW_WINDOW_CYCLES    (`PRW_WINDOW_NS / `PRW_CLK_PERIOD_NS)
`define PRW_RESET_NS         100000000
`define PRW_RESET_CYCLES     (`PRW_RESET_NS / `PRW_CLK_PERIOD_NS)
`define PRW_BLINK_NS         250000000
`define PRW_BLINK_CYCLES     (`PRW_BLINK_NS / `PRW_CLK_PERIOD_NS)
`define PRW_MAX_ATTEMPTS     3

`endif

// ---- prw_pkg.sv ----
// Types for the processor reset watchdog
`default_nettype none

package prw_pkg;
  // ==========================================================
  // Supervisor states
  typedef enum logic [1:0] {
    PRW_RUN,
    PRW_RESET,
    PRW_RECOVER
  } prw_state_e;
endpackage

`default_nettype wire

// ---- prw_timer.sv ----
// Down-counting interval timer with load and expiry flag
`timescale 1ns/100ps
`default_nettype none

module prw_timer #(
  parameter int WIDTH = 26
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Control
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  // Status
  output logic                  o_expired
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire              at_zero = (cnt_q == '0);

  assign cnt_d     = i_load ? i_count : (at_zero ? cnt_q : cnt_q - 1'b1);
  // Flag ignores the load so that reload logic around it forms no loop
  assign o_expired = at_zero;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '1;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // prw_timer

`default_nettype wire

// ---- prw_watchdog.sv ----
// Processor reset watchdog: supervision, reset retries, lamp and alarm
// ==========================================================
// Overview of operation
// - Trip after one second without kick pulse
// - Trip resets processor, three attempts before alarm
// - Blink power lamp while resets proceed
// - Power lamp steady on in normal operation
// - Alarm relay after three failed attempts
// - After alarm, keep retrying resets forever
// - Success clears alarm, count, resumes supervision
`timescale 1ns/100ps
`default_nettype none
`include "prw_defs.svh"

module prw_watchdog import prw_pkg::*; #(
  parameter int WINDOW_CYCLES = `PRW_WINDOW_CYCLES,
  parameter int RESET_CYCLES  = `PRW_RESET_CYCLES,
  parameter int BLINK_CYCLES  = `PRW_BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Processor side
  input  wire logic i_kick,
  output logic      o_cpu_reset_n,
  // Indicators
  output logic      o_power_lamp,
  output logic      o_alarm_relay
);
  localparam int TW = 32;

  prw_state_e      state_q;
  prw_state_e      state_d;
  logic [1:0]      attempts_q;
  logic [1:0]      attempts_d;
  logic            alarm_q;
  logic            alarm_d;
  logic            lamp_q;
  logic [TW-1:0]   blink_q;
  logic            cpu_rst_n_q;
  logic            kick_q;
  logic            load;
  logic [TW-1:0]   load_val;
  logic            expired;
  logic            armed_q;
  logic [TW-1:0]   idle_q;
  logic [TW-1:0]   rst_len_q;
  logic [TW-1:0]   still_q;
  logic            lamp_was_q;

  // ==========================================================
  // Counter step shared by the blink divider and the assertion helpers
  function automatic logic [TW-1:0] count_up(input logic [TW-1:0] value, input logic clear);
    return clear ? '0 : value + 1'b1;
  endfunction

  // ==========================================================
  // Kick edge: a held-high kick counts once only
  wire kick_pulse = i_kick & ~kick_q;

  // ==========================================================
  // Timer reload: kick restarts window, entering reset loads reset time
  wire trip       = (state_q != PRW_RESET) && expired && !kick_pulse;
  wire reset_done = (state_q == PRW_RESET) && expired;
  wire ok_kick    = (state_q != PRW_RESET) && kick_pulse;
  wire last_try   = (attempts_q == 2'(`PRW_MAX_ATTEMPTS));

  // A kick landing as the window runs out still counts; the first edge out of
  // reset loads a full window, since the reset value alone would take far longer
  assign load     = trip | reset_done | ok_kick | ~armed_q;
  assign load_val = trip ? TW'(RESET_CYCLES) : TW'(WINDOW_CYCLES);

  prw_timer #(.WIDTH(TW)) u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (load),
    .i_count   (load_val),
    .o_expired (expired)
  );

  // ==========================================================
  // Supervisor
  always_comb begin
    state_d    = state_q;
    attempts_d = attempts_q;
    alarm_d    = alarm_q;
    case (state_q)
      PRW_RUN: begin
        if (trip) begin
          state_d    = PRW_RESET;
          attempts_d = 2'h1;
        end
      end
      PRW_RESET: begin
        if (reset_done) begin
          state_d = PRW_RECOVER;
        end
      end
      PRW_RECOVER: begin
        if (ok_kick) begin
          state_d    = PRW_RUN;
          attempts_d = 2'h0;
          alarm_d    = 1'b0;
        end else if (trip) begin
          state_d = PRW_RESET;
          if (last_try || alarm_q) begin
            alarm_d = 1'b1;
          end else begin
            attempts_d = attempts_q + 2'h1;
          end
        end
      end
      default: begin
        state_d = PRW_RUN;
      end
    endcase
  end

  // Lamp blinks only while recovery is under way; steady otherwise
  wire recovering = (state_q != PRW_RUN);
  wire blink_end  = (blink_q == TW'(BLINK_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q     <= PRW_RUN;
      attempts_q  <= 2'h0;
      alarm_q     <= 1'b0;
      kick_q      <= 1'b0;
      cpu_rst_n_q <= 1'b1;
      lamp_q      <= 1'b1;
      blink_q     <= '0;
      armed_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      attempts_q  <= attempts_d;
      alarm_q     <= alarm_d;
      kick_q      <= i_kick;
      cpu_rst_n_q <= (state_d != PRW_RESET);
      armed_q     <= 1'b1;
      blink_q     <= count_up(blink_q, !recovering || blink_end);
      if (!recovering) begin
        lamp_q <= 1'b1;
      end else if (blink_end) begin
        lamp_q <= ~lamp_q;
      end
    end
  end

  // ==========================================================
  // Assertion helpers: spans too long to unroll are counted instead
  wire lamp_moved = (lamp_q != lamp_was_q);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idle_q     <= '0;
      rst_len_q  <= '0;
      still_q    <= '0;
      lamp_was_q <= 1'b1;
    end else begin
      idle_q     <= count_up(idle_q, (state_q == PRW_RESET) || !armed_q || kick_pulse);
      rst_len_q  <= count_up(rst_len_q, cpu_rst_n_q);
      still_q    <= count_up(still_q, !recovering || lamp_moved);
      lamp_was_q <= lamp_q;
    end
  end

  assign o_cpu_reset_n = cpu_rst_n_q;
  assign o_power_lamp  = lamp_q;
  assign o_alarm_relay = alarm_q;

  // ==========================================================
  // Assertions
  sequence s_trip;
    state_q != PRW_RESET && expired && !kick_pulse;
  endsequence

  sequence s_enter_reset;
    ##1 !o_cpu_reset_n;
  endsequence

  trip_resets_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_trip |-> s_enter_reset) else $error("trip did not reset processor");

  reset_len_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(o_cpu_reset_n) |-> !o_cpu_reset_n [*8]) else $error("reset pulse too short");

  run_lamp_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_q == PRW_RUN && $past(state_q) == PRW_RUN |-> o_power_lamp)
    else $error("lamp not steady in normal run");

  alarm_third_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_q == PRW_RECOVER && trip && attempts_q == 2'h3 |=> o_alarm_relay)
    else $error("alarm missing after third attempt");

  alarm_retry_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_alarm_relay && trip |=> state_q == PRW_RESET) else $error("retry stopped after alarm");

  success_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_q == PRW_RECOVER && kick_pulse |=> !o_alarm_relay && attempts_q == 2'h0
    && state_q == PRW_RUN) else $error("success did not clear alarm");

  no_alarm_early_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_alarm_relay) |-> $past(attempts_q) == 2'h3) else $error("alarm raised early");

  kick_rearm_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_q != PRW_RESET && kick_pulse |=> !expired) else $error("kick did not rearm");

  sequence s_reset_over;
    state_q == PRW_RESET && expired;
  endsequence

  sequence s_released;
    ##1 o_cpu_reset_n && state_q == PRW_RECOVER;
  endsequence

  release_recover_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_reset_over |-> s_released) else $error("reset not released after pulse");

  reset_exact_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_cpu_reset_n) |-> rst_len_q == TW'(RESET_CYCLES + 1))
    else $error("reset pulse length wrong");

  fall_window_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(o_cpu_reset_n) |-> $past(idle_q) == TW'(WINDOW_CYCLES))
    else $error("reset did not follow one quiet window");

  window_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    idle_q <= TW'(WINDOW_CYCLES + 1)) else $error("quiet window overran without trip");

  blink_lamp_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    still_q <= TW'(BLINK_CYCLES)) else $error("lamp stopped blinking in recovery");

  alarm_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_alarm_relay && !kick_pulse |=> o_alarm_relay) else $error("alarm dropped without success");

endmodule // prw_watchdog

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the processor reset watchdog
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t value mismatch", $time); end end

module tb_top;
  localparam int WIN = 64;
  localparam int RST = 16;
  logic       clk, rst_n, kick, cpu_rst_n, lamp, alarm, healthy, steady, prev_rst, saw_dark;
  logic [7:0] period;
  int         mismatches, compares, cycles, seed, low_len, gap;
  logic       exp_q[$];

  prw_watchdog #(.WINDOW_CYCLES(WIN), .RESET_CYCLES(RST), .BLINK_CYCLES(4)) i_prw_watchdog (
    .i_clk(clk), .i_reset_n(rst_n), .i_kick(kick), .o_cpu_reset_n(cpu_rst_n),
    .o_power_lamp(lamp), .o_alarm_relay(alarm));
  prw_cpu_model i_prw_cpu_model (.i_clk(clk), .i_cpu_reset_n(cpu_rst_n),
    .i_healthy(healthy), .i_period(period), .o_kick(kick));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang the program; recover during the last of n attempts
  task hang(input int n);
    healthy = 1'b0;
    steady  = 1'b0;
    period  = 8'h02;
    for (int i = 0; i < n; i++) exp_q.push_back(i >= 3);
    repeat (n) @(negedge cpu_rst_n);
    @(negedge clk);
    healthy = 1'b1;
    @(posedge cpu_rst_n);
    repeat (8) @(negedge clk);
    steady = 1'b1;
    repeat (100) @(negedge clk);
    `CHK(exp_q.size(), 0)
    $display("test hang %0d attempts done", n);
  endtask

  // ==========================================================
  // Monitor: pulse length, blinking, alarm per attempt
  always @(negedge clk) begin
    cycles++;
    if (steady) begin
      `CHK(lamp, 1'b1)
      `CHK(alarm, 1'b0)
    end
    if (!cpu_rst_n && prev_rst) begin
      `CHK((gap >= WIN) && (gap <= WIN + 4), 1'b1)
      low_len  = 0;
      saw_dark = 1'b0;
    end
    if (!cpu_rst_n) begin
      low_len++;
      if (lamp === 1'b0) saw_dark = 1'b1;
    end
    if (cpu_rst_n && !prev_rst) begin
      `CHK(low_len, RST + 1)
      `CHK(saw_dark, 1'b1)
      `CHK(alarm, exp_q.pop_front())
    end
    gap = (kick === 1'b1 || (cpu_rst_n && !prev_rst)) ? 0 : gap + 1;
    prev_rst = cpu_rst_n;
    if (cycles == 20000) begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  end

  initial begin
    seed = 32'h10b79988;
    {mismatches, compares, cycles, gap, low_len} = '0;
    {rst_n, healthy, steady, saw_dark, prev_rst} = 5'h01;
    period = 8'h10;
    repeat (16) @(negedge clk);
    `CHK({cpu_rst_n, lamp, alarm}, 3'h6)
    rst_n   = 1'b1;
    healthy = 1'b1;
    repeat (4) @(negedge clk);
    steady = 1'b1;
    for (int i = 0; i < 31; i++) begin
      period = (i == 30) ? 8'(WIN - 3) : 8'($unsigned($random(seed)) % 57);
      repeat (100) @(negedge clk);
    end
    $display("test steady kicks done");
    hang(5);
    hang(4);
    hang(1);
    print_verdict();
  end
endmodule // tb_top

`undef CHK
`default_nettype wire
